// >>> design/ppa_top.sv
// peripheral pin assignment top: wishbone register front end holding
// the i2c and serial port routing selectors, plus the pin crossbar.
// assumes a classic wishbone master on clk_i; pins are asynchronous.
//
// Summary of operation
// R1: i2c1 clock selector bits 15:12, eight listed pins, reset zero.
// R2: i2c1 data selector bits 11:8, eight listed pins, reset zero.
// R3: i2c0 clock selector bits 7:4, eight listed pins, reset zero.
// R4: i2c0 data selector bits 3:0, eight listed pins, reset zero.
// R5: i2c register bits 31:16 are read only and read zero.
// R6: serial1 chip select selector bits 31:28, ten pins, reset zero.
// R7: serial1 clock selector bits 27:24, ten listed pins, reset zero.
// R8: serial1 mosi selector bits 23:20, ten listed pins, reset zero.
// R9: serial1 miso selector bits 19:16, ten listed pins, reset zero.
// R10: serial0 chip select selector bits 15:12, ten pins, reset zero.
// R11: serial0 clock selector bits 11:8, ten listed pins, reset zero.
// R12: serial0 mosi selector bits 7:4, ten listed pins, reset zero.
// R13: serial0 miso selector bits 3:0, ten listed pins, reset zero.
// R14: an unlisted selector code connects the signal to no pin.
// R15: fields read back as last written, with no side effects.
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`default_nettype none

module ppa_top
	import ppa_pkg::*;
#(
	parameter int ADR_W = 4
) (
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// wishbone slave
	input  wire logic [ADR_W-1:0]    adr_i,
	input  wire logic [31:0]         dat_i,
	output logic      [31:0]         dat_o,
	input  wire logic [3:0]          sel_i,
	input  wire logic                we_i,
	input  wire logic                cyc_i,
	input  wire logic                stb_i,
	output logic                     ack_o,
	// controller side, bit n is signal n
	input  wire logic [PPA_NSIG-1:0] ctl_out_i,
	input  wire logic [PPA_NSIG-1:0] ctl_oe_i,
	output logic      [PPA_NSIG-1:0] ctl_in_o,
	// port pins, bit port*16+n
	input  wire logic [PPA_NPIN-1:0] pin_in_i,
	output logic      [PPA_NPIN-1:0] pin_out_o,
	output logic      [PPA_NPIN-1:0] pin_oe_o
);
	logic                  ack_r;
	logic [31:0]           dat_r;
	logic [PPA_I2C_W-1:0]  i2c_r;
	logic [PPA_I2C_W-1:0]  i2c_nxt;
	logic [31:0]           ser_r;
	logic [31:0]           ser_nxt;
	logic [31:0]           i2c_word;
	logic [31:0]           stat_word;
	logic [31:0]           rd_val;
	logic                  req_new;
	logic                  wr_ack;
	logic                  hit_i2c;
	logic                  hit_ser;
	logic                  hit_stat;
	logic [PPA_NPIN-1:0]   pin_s;
	logic [3:0]            code [PPA_NSIG];
	logic [PPA_NSIG-1:0]   ok;

	ppa_xbar_if xif ();

	// the decode compares whole byte addresses, so it needs room
	if (ADR_W < 4 || ADR_W > 8) begin : g_bad_adr
		$error("ppa_top: ADR_W out of range");
	end

	// bus handshake: a fresh request is answered the next cycle and
	// a write lands on the edge that sees ack high
	assign req_new = cyc_i & stb_i & ~ack_r;
	assign wr_ack  = cyc_i & stb_i & we_i & ack_r;
	assign ack_o   = ack_r;
	assign dat_o   = dat_r;

	// address decode, misaligned addresses fall to unmapped
	assign hit_i2c  = adr_i == ADR_W'(PPA_ADR_I2C);
	assign hit_ser  = adr_i == ADR_W'(PPA_ADR_SER);
	assign hit_stat = adr_i == ADR_W'(PPA_ADR_STAT);

	// readback words; upper half of the i2c word is tied to zero
	assign i2c_word  = {PPA_ZERO[31:PPA_I2C_W], i2c_r}; // R5
	assign stat_word = {PPA_ZERO[31:PPA_NSIG], ok};

	// read selection
	always_comb begin
		if (hit_i2c) begin
			rd_val = i2c_word; // R15
		end else if (hit_ser) begin
			rd_val = ser_r; // R15
		end else if (hit_stat) begin
			rd_val = stat_word;
		end else begin
			rd_val = PPA_UNMAP;
		end
	end

	// byte lane merge; the i2c register has only the two low lanes
	for (genvar b = 0; b < PPA_NLANE; b++) begin : g_lane
		assign ser_nxt[b*PPA_LANE_W +: PPA_LANE_W] =
			(wr_ack && hit_ser && sel_i[b]) ?
			dat_i[b*PPA_LANE_W +: PPA_LANE_W] :
			ser_r[b*PPA_LANE_W +: PPA_LANE_W]; // R6 R7 R8 R9
		if (b < PPA_I2C_W / PPA_LANE_W) begin : g_i2c
			assign i2c_nxt[b*PPA_LANE_W +: PPA_LANE_W] =
				(wr_ack && hit_i2c && sel_i[b]) ?
				dat_i[b*PPA_LANE_W +: PPA_LANE_W] :
				i2c_r[b*PPA_LANE_W +: PPA_LANE_W]; // R1 R2 R3 R4
		end
	end

	// handshake and read data registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= PPA_ZERO;
		end else begin
			ack_r <= req_new;
			dat_r <= req_new ? rd_val : dat_r;
		end
	end

	// selector registers; any code is stored, reserved ones included
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			i2c_r <= PPA_I2C_RST; // R1 R2 R3 R4
			ser_r <= PPA_SER_RST; // R10 R11 R12 R13
		end else begin
			i2c_r <= i2c_nxt; // R15
			ser_r <= ser_nxt; // R10 R11 R12 R13
		end
	end

	// per signal selector code and whether it is a listed one
	for (genvar s = 0; s < PPA_NSIG; s++) begin : g_code
		assign code[s]        = ppa_code(s, i2c_word, ser_r);
		assign ok[s]          = ppa_code_ok(s, code[s]); // R14
		assign xif.code[s]    = code[s];
	end
	assign xif.ok      = ok;
	assign xif.drv_out = ctl_out_i;
	assign xif.drv_oe  = ctl_oe_i;

	// pins come from outside the clock domain
	ppa_sync #(
		.W   (PPA_NPIN)
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (pin_in_i),
		.q_o   (pin_s)
	);

	// crossbar adds one cycle each way; fine for i2c and slow spi
	ppa_xbar u_xbar (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.x         (xif.xbar),
		.pin_s_i   (pin_s),
		.pin_out_o (pin_out_o),
		.pin_oe_o  (pin_oe_o),
		.ctl_in_o  (ctl_in_o)
	);

	// ---------------- checks ----------------
	default clocking cb @(posedge clk_i);
	endclocking
	// reset seen one edge late as well: attempts launched on the
	// release edge stay off whichever region order the tool picks
	logic rst_d_r;
	always_ff @(posedge clk_i) begin
		rst_d_r <= rst_i;
	end
	default disable iff (rst_i || rst_d_r);

	// helper: pin picked by the highest priority signal
	logic [5:0] pin0;
	assign pin0 = PPA_PIN_TBL[0][ok[0] ? code[0] : 4'h0];

	// request answered exactly one cycle later
	wb_ack_a: assert property ( // R15
		req_new |=> ack_o ##1 !ack_o)
		else $error("ack not one cycle after request");

	// no ack without a request held
	ack_cause_a: assert property ( // R15
		ack_o |-> $past(cyc_i & stb_i) && cyc_i && stb_i)
		else $error("ack without a held request");

	// upper half of the i2c word never reads nonzero
	i2c_resv_a: assert property ( // R5
		ack_o && !we_i && hit_i2c |-> dat_o[31:PPA_I2C_W] == '0)
		else $error("i2c reserved bits read nonzero");

	// i2c readback equals the last full word written
	i2c_back_a: assert property ( // R1
		wr_ack && hit_i2c && sel_i == 4'hf
		##1 (!wr_ack)[*2]
		|-> i2c_r == $past(dat_i[PPA_I2C_W-1:0], 3))
		else $error("i2c selectors lost written value");

	// serial readback equals the last full word written
	ser_back_a: assert property ( // R6
		wr_ack && hit_ser && sel_i == 4'hf
		|=> ser_r == $past(dat_i) && dat_o == $past(dat_o))
		else $error("serial selectors lost written value");

	// unselected byte lane 0 of the serial register keeps its value
	lane_keep_a: assert property ( // R10
		wr_ack && hit_ser && !sel_i[0]
		|=> ser_r[PPA_LANE_W-1:0] == $past(ser_r[PPA_LANE_W-1:0]))
		else $error("serial lane changed without byte enable");

	// both registers stand still without a write
	reg_hold_a: assert property ( // R15
		!wr_ack |=> $stable(ser_r) && $stable(i2c_r))
		else $error("selector changed without a write");

	// reads leave every selector untouched
	read_side_a: assert property ( // R15
		ack_o && !we_i |=> $stable(ser_r) && $stable(i2c_r))
		else $error("read changed a selector");

	// i2c selectors decode from the documented field positions
	i2c_fld_a: assert property ( // R2
		code[0] == i2c_r[15:12] && code[1] == i2c_r[11:8] &&
		code[2] == i2c_r[7:4] && code[3] == i2c_r[3:0])
		else $error("i2c field positions wrong");

	// serial selectors decode from the documented field positions
	ser_fld_a: assert property ( // R7
		code[4] == ser_r[31:28] && code[5] == ser_r[27:24] &&
		code[6] == ser_r[23:20] && code[7] == ser_r[19:16] &&
		code[8] == ser_r[15:12] && code[9] == ser_r[11:8] &&
		code[10] == ser_r[7:4] && code[11] == ser_r[3:0])
		else $error("serial field positions wrong");

	// i2c codes eight and above are reserved, serial ten and above
	code_range_a: assert property ( // R14
		ok[3] == (i2c_r[3:0] <= 4'h7) && ok[8] == (ser_r[15:12] <= 4'h9))
		else $error("listed code range wrong");

	// first signal drives its pin one cycle after it asks
	route_out_a: assert property ( // R3
		ok[0] && $stable(pin0) |=> pin_oe_o[$past(pin0)] ==
		$past(ctl_oe_i[0]) && pin_out_o[$past(pin0)] ==
		$past(ctl_out_i[0]))
		else $error("i2c1 clock not on its pin");

	// returned level follows the selected pin after one cycle
	route_in_a: assert property ( // R4
		ok[0] |=> ctl_in_o[0] == $past(pin_s[pin0]))
		else $error("i2c1 clock input not from its pin");

	// serial0 miso at code zero listens on port 0 bit 2
	miso_pin_a: assert property ( // R13
		ser_r[3:0] == 4'h0 |=> ctl_in_o[11] == $past(pin_s[6'h02]))
		else $error("serial0 miso reset pin wrong");

	// serial port 0 mosi at code nine uses port 2 bit 13
	mosi_pin_a: assert property ( // R12
		ser_r[7:4] == 4'h9 |=> ctl_in_o[10] == $past(pin_s[6'h2d]))
		else $error("serial0 mosi code nine pin wrong");

	// i2c1 clock at code three listens on port 1 bit 9
	scl1_pin_a: assert property ( // R1
		i2c_r[15:12] == 4'h3 |=> ctl_in_o[0] == $past(pin_s[6'h19]))
		else $error("i2c1 clock code three pin wrong");

	// i2c1 data at code seven listens on port 3 bit 12
	sda1_pin_a: assert property ( // R2
		i2c_r[11:8] == 4'h7 |=> ctl_in_o[1] == $past(pin_s[6'h3c]))
		else $error("i2c1 data code seven pin wrong");

	// i2c0 clock at code two listens on port 0 bit 15
	scl0_pin_a: assert property ( // R3
		i2c_r[7:4] == 4'h2 |=> ctl_in_o[2] == $past(pin_s[6'h0f]))
		else $error("i2c0 clock code two pin wrong");

	// i2c0 data at code six listens on port 3 bit 13
	sda0_pin_a: assert property ( // R4
		i2c_r[3:0] == 4'h6 |=> ctl_in_o[3] == $past(pin_s[6'h3d]))
		else $error("i2c0 data code six pin wrong");

	// serial1 chip select at code nine listens on port 2 bit 14
	cs1_pin_a: assert property ( // R6
		ser_r[31:28] == 4'h9 |=> ctl_in_o[4] == $past(pin_s[6'h2e]))
		else $error("serial1 chip select code nine pin wrong");

	// serial1 clock at code four listens on port 1 bit 11
	sck1_pin_a: assert property ( // R7
		ser_r[27:24] == 4'h4 |=> ctl_in_o[5] == $past(pin_s[6'h1b]))
		else $error("serial1 clock code four pin wrong");

	// serial1 mosi at code eight listens on port 2 bit 0
	mosi1_pin_a: assert property ( // R8
		ser_r[23:20] == 4'h8 |=> ctl_in_o[6] == $past(pin_s[6'h20]))
		else $error("serial1 mosi code eight pin wrong");

	// serial1 miso at code five listens on port 3 bit 0
	miso1_pin_a: assert property ( // R9
		ser_r[19:16] == 4'h5 |=> ctl_in_o[7] == $past(pin_s[6'h30]))
		else $error("serial1 miso code five pin wrong");

	// serial0 chip select at code three listens on port 1 bit 5
	cs0_pin_a: assert property ( // R10
		ser_r[15:12] == 4'h3 |=> ctl_in_o[8] == $past(pin_s[6'h15]))
		else $error("serial0 chip select code three pin wrong");

	// serial0 clock at code seven listens on port 3 bit 11
	sck0_pin_a: assert property ( // R11
		ser_r[11:8] == 4'h7 |=> ctl_in_o[9] == $past(pin_s[6'h3b]))
		else $error("serial0 clock code seven pin wrong");

	// serial0 mosi at code zero listens on port 0 bit 3
	mosi0_pin_a: assert property ( // R12
		ser_r[7:4] == 4'h0 |=> ctl_in_o[10] == $past(pin_s[6'h03]))
		else $error("serial0 mosi code zero pin wrong");

	// serial0 miso at code nine listens on port 2 bit 12
	miso0_pin_a: assert property ( // R13
		ser_r[3:0] == 4'h9 |=> ctl_in_o[11] == $past(pin_s[6'h2c]))
		else $error("serial0 miso code nine pin wrong");

	// a reserved code leaves the input idle
	for (genvar s = 0; s < PPA_NSIG; s++) begin : g_chk
		resv_in_a: assert property ( // R14
			!ok[s] |=> ctl_in_o[s] == PPA_IDLE_IN)
			else $error("reserved code still routes an input");
	end

	// with every code reserved no pin is driven
	resv_drive_a: assert property ( // R14
		ok == '0 |=> pin_oe_o == '0)
		else $error("pin driven with all codes reserved");

	// reset state: serial selectors at the first candidate
	rst_val_a: assert property ( // R11
		$rose(ack_o) && $past(rst_i, 2) |-> ser_r == PPA_SER_RST)
		else $error("selectors not cleared by reset");

	// coverage of the main scenarios
	cov_write_c: cover property (wr_ack && hit_ser ##2 ack_o && !we_i);
	cov_resv_c:  cover property (!ok[4] ##1 wr_ack && hit_ser);
	cov_i2c_c:   cover property (ok[0] && code[0] == 4'h7);
	cov_unmap_c: cover property (ack_o && !hit_i2c && !hit_ser &&
		!hit_stat);
	cov_stat_c:  cover property (ack_o && !we_i && hit_stat);

endmodule : ppa_top

`default_nettype wire

// >>> include/ppa_pkg.sv
// package for the peripheral pin assignment block: register map,
// field layout and the pin lookup tables for each routed signal.
// assumes pins are numbered port*16+bit, ports 0 to 3.
`default_nettype none

package ppa_pkg;

	// sizes
	localparam int PPA_NSIG   = 12;
	localparam int PPA_NPIN   = 64;
	localparam int PPA_NCODE  = 10;
	localparam int PPA_FLD_W  = 4;
	localparam int PPA_PIN_W  = 6;
	localparam int PPA_LANE_W = 8;
	localparam int PPA_NLANE  = 4;
	localparam int PPA_I2C_W  = 16;

	// byte addresses of the registers
	localparam logic [7:0] PPA_ADR_I2C  = 8'h00;
	localparam logic [7:0] PPA_ADR_SER  = 8'h04;
	localparam logic [7:0] PPA_ADR_STAT = 8'h08;

	// reset values and fixed read values
	localparam logic [31:0] PPA_SER_RST = 32'h0000_0000;
	localparam logic [15:0] PPA_I2C_RST = 16'h0000;
	localparam logic [31:0] PPA_ZERO    = 32'h0000_0000;
	localparam logic [31:0] PPA_UNMAP   = 32'h0000_0000;
	localparam logic        PPA_IDLE_IN = 1'b1;

	// signal order: i2c1 scl, i2c1 sda, i2c0 scl, i2c0 sda,
	// port1 cs, sck, mosi, miso, port0 cs, sck, mosi, miso
	localparam logic PPA_FLD_SER [0:PPA_NSIG-1] = '{
		1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1,
		1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
	localparam int PPA_FLD_LSB [0:PPA_NSIG-1] = '{
		12, 8, 4, 0, 28, 24, 20, 16, 12, 8, 4, 0};
	localparam logic [3:0] PPA_NCODE_OF [0:PPA_NSIG-1] = '{
		4'h8, 4'h8, 4'h8, 4'h8, 4'ha, 4'ha,
		4'ha, 4'ha, 4'ha, 4'ha, 4'ha, 4'ha};

	// pin per code, hex digits read as port and bit
	localparam logic [5:0] PPA_PIN_TBL [0:PPA_NSIG-1][0:PPA_NCODE-1] = '{
		'{6'h06, 6'h00, 6'h11, 6'h19, 6'h30, 6'h33, 6'h36, 6'h3d,
		  6'h00, 6'h00},
		'{6'h07, 6'h01, 6'h10, 6'h18, 6'h32, 6'h34, 6'h35, 6'h3c,
		  6'h00, 6'h00},
		'{6'h15, 6'h02, 6'h0f, 6'h13, 6'h1e, 6'h39, 6'h3b, 6'h3e,
		  6'h00, 6'h00},
		'{6'h14, 6'h03, 6'h0a, 6'h12, 6'h1d, 6'h37, 6'h3d, 6'h3f,
		  6'h00, 6'h00},
		'{6'h36, 6'h02, 6'h0d, 6'h10, 6'h14, 6'h17, 6'h1e, 6'h3b,
		  6'h21, 6'h2e},
		'{6'h37, 6'h07, 6'h0e, 6'h11, 6'h1b, 6'h1f, 6'h33, 6'h3e,
		  6'h22, 6'h2d},
		'{6'h38, 6'h05, 6'h0c, 6'h12, 6'h16, 6'h1d, 6'h32, 6'h3d,
		  6'h20, 6'h2f},
		'{6'h39, 6'h04, 6'h0a, 6'h13, 6'h1a, 6'h30, 6'h34, 6'h3c,
		  6'h21, 6'h2c},
		'{6'h05, 6'h0a, 6'h0c, 6'h15, 6'h1b, 6'h31, 6'h35, 6'h3a,
		  6'h20, 6'h2f},
		'{6'h04, 6'h0b, 6'h0d, 6'h14, 6'h1c, 6'h32, 6'h36, 6'h3b,
		  6'h23, 6'h2e},
		'{6'h03, 6'h01, 6'h07, 6'h0e, 6'h11, 6'h1f, 6'h34, 6'h3e,
		  6'h22, 6'h2d},
		'{6'h02, 6'h00, 6'h06, 6'h0f, 6'h10, 6'h1e, 6'h33, 6'h3f,
		  6'h21, 6'h2c}};

	// selector field of one signal out of the two registers
	function automatic logic [3:0] ppa_code(input int s,
		input logic [31:0] i2c, input logic [31:0] ser);
		logic [31:0] r;
		r = PPA_FLD_SER[s] ? ser : i2c;
		return r[PPA_FLD_LSB[s] +: PPA_FLD_W];
	endfunction : ppa_code

	// listed codes route, the rest connect nothing
	function automatic logic ppa_code_ok(input int s,
		input logic [3:0] c);
		return c < PPA_NCODE_OF[s];
	endfunction : ppa_code_ok

endpackage : ppa_pkg

`default_nettype wire

// >>> include/ppa_xbar_if.sv
// carrier between the register front end and the routing crossbar.
// assumes one clock domain; codes are already decoded per signal.
`default_nettype none

interface ppa_xbar_if;
	import ppa_pkg::*;
	logic [3:0]          code    [PPA_NSIG];
	logic [PPA_NSIG-1:0] ok;
	logic [PPA_NSIG-1:0] drv_out;
	logic [PPA_NSIG-1:0] drv_oe;
	modport front (output code, output ok, output drv_out, output drv_oe);
	modport xbar  (input code, input ok, input drv_out, input drv_oe);
endinterface : ppa_xbar_if

`default_nettype wire

// >>> design/ppa_sync.sv
// two flip-flop synchroniser for the port pin levels.
// assumes asynchronous inputs; only the second stage is read.
`default_nettype none

module ppa_sync #(
	parameter int W = 64
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// levels
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	// refused at elaboration, a zero width has nothing to carry
	if (W < 1) begin : g_bad_w
		$error("ppa_sync: width must be positive");
	end

	// first stage feeds the second only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			q_o    <= '0;
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule : ppa_sync

`default_nettype wire

// >>> design/ppa_xbar.sv
// routing crossbar: drives each pin from the first signal routed to it
// and returns the selected pin level to each signal, all registered.
// assumes synchronised pin levels and same-clock controller drives.
`default_nettype none

module ppa_xbar
	import ppa_pkg::*;
(
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// routing and controller drives
	ppa_xbar_if.xbar                 x,
	// pins
	input  wire logic [PPA_NPIN-1:0] pin_s_i,
	output logic      [PPA_NPIN-1:0] pin_out_o,
	output logic      [PPA_NPIN-1:0] pin_oe_o,
	// controller side
	output logic      [PPA_NSIG-1:0] ctl_in_o
);
	logic [5:0]          pin_of [PPA_NSIG];
	logic [PPA_NSIG-1:0] in_nxt;
	logic [PPA_NPIN-1:0] out_nxt;
	logic [PPA_NPIN-1:0] oe_nxt;

	// pin chosen by each signal; reserved codes read as unrouted
	for (genvar s = 0; s < PPA_NSIG; s++) begin : g_sig
		assign pin_of[s] = PPA_PIN_TBL[s][x.ok[s] ? x.code[s] : 4'h0];
		assign in_nxt[s] = x.ok[s] ? pin_s_i[pin_of[s]] : PPA_IDLE_IN; // R14
	end

	// lowest signal number wins a shared pin, others are cut off
	for (genvar p = 0; p < PPA_NPIN; p++) begin : g_pin
		logic o;
		logic e;
		always_comb begin
			o = 1'b0;
			e = 1'b0;
			for (int s = PPA_NSIG - 1; s >= 0; s--) begin
				if (x.ok[s] && pin_of[s] == PPA_PIN_W'(p)) begin // R14
					o = x.drv_out[s];
					e = x.drv_oe[s];
				end
			end
		end
		assign out_nxt[p] = o;
		assign oe_nxt[p]  = e;
	end

	// one register stage in both directions
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_out_o <= '0;
			pin_oe_o  <= '0;
			ctl_in_o  <= {PPA_NSIG{PPA_IDLE_IN}};
		end else begin
			pin_out_o <= out_nxt;
			pin_oe_o  <= oe_nxt;
			ctl_in_o  <= in_nxt;
		end
	end
endmodule : ppa_xbar

`default_nettype wire

// >>> sim/ppa_pins_model.sv
// pin model for the far side: a port pin follows the block's drive
// while enabled, otherwise the board level that the bench applies.
// assumes no pull resistors, so a released pin shows the board level.
`default_nettype none

module ppa_pins_model
	import ppa_pkg::*;
(
	// block drives
	input  wire logic [PPA_NPIN-1:0] pin_out_i,
	input  wire logic [PPA_NPIN-1:0] pin_oe_i,
	// board level on released pins, changed by the bench per check
	input  wire logic [PPA_NPIN-1:0] ext_i,
	// levels seen by the block
	output logic      [PPA_NPIN-1:0] pin_in_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// enabled pins carry the drive, released ones the board level
	assign pin_in_o = (pin_out_i & pin_oe_i) | (ext_i & ~pin_oe_i);

endmodule : ppa_pins_model

`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the pin assignment block: register access,
// every listed selector code, reserved codes and read-back.
// assumes the pin model closes the loop from pin drives to pin levels.
`default_nettype none

module tb_top
	import ppa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// bus, controller and pin signals
	logic                clk_i, rst_i, we_i, cyc_i, stb_i, ack_o;
	logic [3:0]          adr_i, sel_i, ra;
	logic [31:0]         dat_i, dat_o, rnd_s, rr;
	logic [PPA_NSIG-1:0] ctl_out_i, ctl_oe_i, ctl_in_o;
	logic [PPA_NPIN-1:0] pin_in_i, pin_out_o, pin_oe_o, ext_lvl;
	logic [31:0]         rm [2];
	logic [31:0]         exp_q [$];
	int                  failures, n_compared;

	// pin per code, hex digits read as port and bit
	localparam logic [0:11][0:9][7:0] PIN_TBL = {
		80'h06_00_11_19_30_33_36_3d_00_00,
		80'h07_01_10_18_32_34_35_3c_00_00,
		80'h15_02_0f_13_1e_39_3b_3e_00_00,
		80'h14_03_0a_12_1d_37_3d_3f_00_00,
		80'h36_02_0d_10_14_17_1e_3b_21_2e,
		80'h37_07_0e_11_1b_1f_33_3e_22_2d,
		80'h38_05_0c_12_16_1d_32_3d_20_2f,
		80'h39_04_0a_13_1a_30_34_3c_21_2c,
		80'h05_0a_0c_15_1b_31_35_3a_20_2f,
		80'h04_0b_0d_14_1c_32_36_3b_23_2e,
		80'h03_01_07_0e_11_1f_34_3e_22_2d,
		80'h02_00_06_0f_10_1e_33_3f_21_2c};

	// 25 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	ppa_top #(.ADR_W(4)) ppa_top_i (
		.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
		.dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .ack_o(ack_o), .ctl_out_i(ctl_out_i),
		.ctl_oe_i(ctl_oe_i), .ctl_in_o(ctl_in_o), .pin_in_i(pin_in_i),
		.pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));

	ppa_pins_model ppa_pins_model_i (
		.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .ext_i(ext_lvl),
		.pin_in_o(pin_in_i));

	// xorshift source, fixed seed set in the main sequence
	function automatic logic [31:0] rnd();
		rnd_s = rnd_s ^ (rnd_s << 13);
		rnd_s = rnd_s ^ (rnd_s >> 17);
		rnd_s = rnd_s ^ (rnd_s << 5);
		return rnd_s;
	endfunction : rnd

	task automatic print_verdict();
		if (failures == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic check1(input logic got, input logic exp);
		check({63'h0, got}, {63'h0, exp});
	endtask : check1

	// one classic cycle; waits for ack, never assumes its latency,
	// a hung wait is ended by the watchdog
	task automatic bus(input logic [3:0] a, input logic w,
		input logic [31:0] d, input logic [3:0] s);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		adr_i <= a;
		we_i  <= w;
		dat_i <= d;
		sel_i <= s;
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	// writes keep a copy of the registers for later reads
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s);
		for (int b = 0; b < 4; b++)
			if (s[b] && !a[3]) rm[a[2]][8*b +: 8] = d[8*b +: 8];
		bus(a, 1'b1, d, s);
	endtask : wr

	// expected read data is queued before the cycle starts
	task automatic rd(input logic [3:0] a);
		logic [31:0] e;
		e = a[3] ? 32'h0000_0000 : rm[a[2]];
		if (a == 4'h0) e[31:16] = 16'h0000;
		// status bit n: signal n holds a listed code
		if (a == 4'h8)
			for (int s = 0; s < PPA_NSIG; s++)
				e[s] = rm[s > 3][((s < 4) ? 12 - 4*s : 44 - 4*s) +: 4]
					< ((s < 4) ? 8 : 10);
		exp_q.push_back(e);
		bus(a, 1'b0, rnd(), 4'hf);
	endtask : rd

	// signal s drives, then releases; pin p must follow both ways
	task automatic drive_chk(input int s, input logic [7:0] p);
		logic [31:0] r;
		logic [63:0] x;
		r = rnd();
		x = {rnd(), rnd()};
		x[p] = ~r[s]; // board opposes the drive, so release shows
		ext_lvl   <= x;
		ctl_out_i <= r[PPA_NSIG-1:0];
		ctl_oe_i  <= PPA_NSIG'(1) << s;
		repeat (5) @(posedge clk_i);
		check(pin_oe_o, 64'h1 << p);
		check1(pin_out_o[p], r[s]);
		check1(ctl_in_o[s], r[s]);
		ctl_oe_i <= '0;
		repeat (5) @(posedge clk_i);
		check(pin_oe_o, 64'h0);
		check1(ctl_in_o[s], ext_lvl[p]);
	endtask : drive_chk

	// all other fields parked on a reserved code
	task automatic route_chk(input int s, input logic [3:0] c);
		logic [31:0] v0, v1;
		int lsb;
		v0 = 32'h0000_ffff;
		v1 = 32'hffff_ffff;
		lsb = (s < 4) ? 12 - 4*s : 44 - 4*s;
		if (s < 4) v0[lsb +: 4] = c;
		else v1[lsb +: 4] = c;
		wr(4'h0, v0, 4'hf);
		wr(4'h4, v1, 4'hf);
		rd(4'h0);
		rd(4'h4);
		drive_chk(s, PIN_TBL[s][c]);
		check1(&(ctl_in_o | (PPA_NSIG'(1) << s)), 1'b1);
	endtask : route_chk

	// read results are taken off the queue as acks appear
	always @(posedge clk_i) begin
		if (cyc_i === 1'b1 && we_i === 1'b0 && ack_o === 1'b1) begin
			if (exp_q.size() == 0) failures++;
			else check({32'h0, dat_o}, {32'h0, exp_q.pop_front()});
		end
	end

	// watchdog, well above the few thousand cycles of the run
	initial begin
		repeat (30000) @(posedge clk_i);
		failures++;
		print_verdict();
	end

	initial begin
		rnd_s = 32'd18812;
		failures = 0;
		n_compared = 0;
		rm[0] = 32'h0000_0000;
		rm[1] = 32'h0000_0000;
		rst_i = 1'b1;
		{cyc_i, stb_i, we_i} = 3'h0;
		adr_i = 4'h0;
		sel_i = 4'h0;
		dat_i = 32'h0000_0000;
		ctl_out_i = '0;
		ctl_oe_i = '0;
		ext_lvl = '0;
		repeat (8) @(posedge clk_i);
		// first request already on the release edge
		rst_i <= 1'b0;
		rd(4'h0);
		rd(4'h4);
		rd(4'h8);
		drive_chk(0, 8'h06);
		drive_chk(11, 8'h02);
		// random words, lanes and addresses, status and unmapped too
		repeat (24) begin
			rr = rnd();
			ra = {rr[1:0], 2'b00};
			wr(ra, rnd(), rr[7:4]);
			rd(ra);
		end
		for (int s = 0; s < PPA_NSIG; s++)
			for (int c = 0; c < ((s < 4) ? 8 : 10); c++)
				route_chk(s, c[3:0]);
		// first reserved code of every field, all controllers driving
		wr(4'h0, 32'hffff_8888, 4'hf);
		wr(4'h4, 32'haaaa_aaaa, 4'hf);
		rd(4'h0);
		rd(4'h4);
		rd(4'h8);
		ext_lvl   <= {rnd(), rnd()};
		ctl_out_i <= '1;
		ctl_oe_i  <= '1;
		repeat (5) @(posedge clk_i);
		check(pin_oe_o, 64'h0);
		check1(&ctl_in_o, 1'b1);
		print_verdict();
	end

endmodule : tb_top

`default_nettype wire
